/* design/cmu_pkg.sv */
// Shared constants, field layouts and helpers of the modem serial port
package cmu_pkg;

  localparam int unsigned CMU_CLK_HZ = 25_000_000;

  // Selectable line rates, index is the rate code
  localparam int unsigned CMU_RATE_BPS [8] = '{
    9600, 19200, 38400, 57600, 115200, 230400, 460800, 921600
  };
  localparam logic [2:0] CMU_RATE_DEFAULT = 3'h4;

  // Register byte addresses
  localparam logic [7:0] CMU_REG_CTRL   = 8'h00;
  localparam logic [7:0] CMU_REG_STATUS = 8'h04;
  localparam logic [7:0] CMU_REG_TXDATA = 8'h08;
  localparam logic [7:0] CMU_REG_RXDATA = 8'h0c;
  localparam logic [7:0] CMU_REG_MODEM  = 8'h10;
  localparam logic [7:0] CMU_REG_MUX    = 8'h14;

  localparam logic [1:0] CMU_PAR_NONE = 2'h0;
  localparam logic [1:0] CMU_PAR_EVEN = 2'h1;
  localparam logic [1:0] CMU_PAR_ODD  = 2'h2;

  localparam logic [1:0] CMU_FLOW_HW   = 2'h0;
  localparam logic [1:0] CMU_FLOW_SW   = 2'h1;
  localparam logic [1:0] CMU_FLOW_NONE = 2'h2;

  localparam logic [1:0] CMU_PSV_OFF = 2'h0;
  localparam logic [1:0] CMU_PSV_SW  = 2'h1;
  localparam logic [1:0] CMU_PSV_RTS = 2'h2;
  localparam logic [1:0] CMU_PSV_DTR = 2'h3;

  localparam logic [7:0] CMU_XON      = 8'h11;
  localparam logic [7:0] CMU_XOFF     = 8'h13;
  localparam logic [7:0] CMU_MUX_FLAG = 8'hf9;
  localparam logic [5:0] CMU_MUX_LAST = 6'h05;

  // Idle bit times required after rate detection before receiving
  localparam logic [3:0] CMU_GUARD_BITS = 4'hb;

  // Status bit positions
  localparam int CMU_ST_PERR = 4;
  localparam int CMU_ST_FERR = 5;
  localparam int CMU_ST_OVR  = 6;

  typedef struct packed {
    logic       mux_en;
    logic       ab_en;
    logic       psv_req;
    logic [1:0] psv_mode;
    logic [1:0] flow;
    logic       two_stop;
    logic [1:0] parity;
    logic       data7;
    logic [2:0] baud;
  } cmu_ctrl_t;

  // Autobaud on, hardware flow, 8N1, default rate
  localparam cmu_ctrl_t CMU_CTRL_RST = 14'h1004;

  function automatic logic [11:0] cmu_bit_cycles(input logic [2:0] sel);
    cmu_bit_cycles = 12'(CMU_CLK_HZ / CMU_RATE_BPS[sel]);
  endfunction

  function automatic logic cmu_par(input logic [7:0] d,
                                   input logic       data7,
                                   input logic [1:0] parity);
    logic p;
    p = data7 ? ^d[6:0] : ^d;
    cmu_par = (parity == CMU_PAR_ODD) ? ~p : p;
  endfunction

  function automatic logic [2:0] cmu_nearest(input logic [11:0] cnt);
    logic [11:0] best;
    logic [11:0] diff;
    logic [11:0] div;
    cmu_nearest = 3'h0;
    best = 12'hfff;
    for (int i = 0; i < 8; i++)
    begin
      div  = cmu_bit_cycles(3'(i));
      diff = (cnt > div) ? cnt - div : div - cnt;
      if (diff < best)
      begin
        best        = diff;
        cmu_nearest = 3'(i);
      end
    end
  endfunction

endpackage

/* design/cmu_uart_port.sv */
// Device-side serial port: framer, rate detect, flow control, mux tracking
//
// Chosen here: the plain strobed port and the placing of the registers.
module cmu_uart_port
  import cmu_pkg::*;
#(
  parameter int DATA_W    = 8,
  parameter int BUF_DEPTH = 2
)(
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wr_data_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  output logic      [31:0] rd_data_o,
  input  wire logic        txd_i,
  input  wire logic        rts_i,
  input  wire logic        dtr_i,
  output logic             rxd_o,
  output logic             cts_o,
  output logic             dsr_o,
  output logic             dcd_o,
  output logic             ri_o
);

  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(BUF_DEPTH);
  localparam logic [PW:0] STOP_CNT = (PW + 1)'(BUF_DEPTH - 1);

  if (DATA_W != 8)
    $error("cmu_uart_port: DATA_W must be 8");
  if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0)
    $error("cmu_uart_port: BUF_DEPTH must be a power of two, at least 2");

  typedef enum logic [4:0] {
    CMU_S_IDLE  = 5'b00001,
    CMU_S_START = 5'b00010,
    CMU_S_DATA  = 5'b00100,
    CMU_S_PAR   = 5'b01000,
    CMU_S_STOP  = 5'b10000
  } cmu_ser_t;

  typedef enum logic [3:0] {
    CMU_AB_WAIT  = 4'b0001,
    CMU_AB_MEAS  = 4'b0010,
    CMU_AB_GUARD = 4'b0100,
    CMU_AB_DONE  = 4'b1000
  } cmu_ab_t;

  cmu_ctrl_t   ctrl;
  logic [2:0]  modem_on;
  logic        perr;
  logic        ferr;
  logic        ovr;
  logic        xoff_rx;
  logic        sent_xoff;
  logic [11:0] bit_cyc;
  logic [2:0]  nbits_m1;
  logic        two_stop;
  logic        sleep;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_tx;
  logic        rd_rx;

  assign bit_cyc   = cmu_bit_cycles(ctrl.baud);
  assign nbits_m1  = ctrl.data7 ? 3'h6 : 3'h7;
  assign two_stop  = ctrl.two_stop && (ctrl.parity == CMU_PAR_NONE);
  assign wr_ctrl   = wr_en_i && (addr_i == CMU_REG_CTRL);
  assign wr_status = wr_en_i && (addr_i == CMU_REG_STATUS);
  assign wr_tx     = wr_en_i && (addr_i == CMU_REG_TXDATA);
  assign rd_rx     = rd_en_i && (addr_i == CMU_REG_RXDATA);

  always_comb
  begin
    unique case (ctrl.psv_mode)
      CMU_PSV_OFF: sleep = 1'b0;
      CMU_PSV_SW:  sleep = ctrl.psv_req;
      CMU_PSV_RTS: sleep = rts_i;
      CMU_PSV_DTR: sleep = dtr_i;
    endcase
  end

  // Rate detection on the first start bit
  cmu_ab_t     ab_st;
  logic [11:0] ab_cnt;
  logic [3:0]  ab_bits;
  logic        ab_found;
  logic [2:0]  ab_sel;
  logic        ab_done;

  assign ab_done = (ab_st == CMU_AB_DONE);

  always_ff @(posedge mclk_i)
  begin
    ab_found <= 1'b0;
    if (sys_rst_i)
    begin
      ab_st   <= CMU_AB_WAIT;
      ab_cnt  <= 12'h000;
      ab_bits <= 4'h0;
      ab_sel  <= CMU_RATE_DEFAULT;
    end
    else
    begin
      unique case (ab_st)
        CMU_AB_WAIT:
        begin
          if (!ctrl.ab_en)
            ab_st <= CMU_AB_DONE;
          else if (!txd_i)
          begin
            ab_st  <= CMU_AB_MEAS;
            ab_cnt <= 12'h001;
          end
        end
        CMU_AB_MEAS:
        begin
          if (txd_i)
          begin
            ab_found <= 1'b1;
            ab_sel   <= cmu_nearest(ab_cnt);
            ab_st    <= CMU_AB_GUARD;
            ab_cnt   <= 12'h000;
            ab_bits  <= 4'h0;
          end
          else if (ab_cnt != 12'hfff)
            ab_cnt <= ab_cnt + 12'h001;
        end
        CMU_AB_GUARD:
        begin
          if (!txd_i)
          begin
            ab_cnt  <= 12'h000;
            ab_bits <= 4'h0;
          end
          else if (ab_cnt >= bit_cyc - 12'h001)
          begin
            ab_cnt  <= 12'h000;
            ab_bits <= ab_bits + 4'h1;
            if (ab_bits == CMU_GUARD_BITS - 4'h1)
              ab_st <= CMU_AB_DONE;
          end
          else
            ab_cnt <= ab_cnt + 12'h001;
        end
        CMU_AB_DONE: ab_st <= CMU_AB_DONE;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      ctrl <= CMU_CTRL_RST;
    else if (wr_ctrl)
      ctrl <= cmu_ctrl_t'(wr_data_i[$bits(cmu_ctrl_t)-1:0]);
    else if (ab_found)
      ctrl.baud <= ab_sel;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      modem_on <= 3'h0;
    else if (wr_en_i && addr_i == CMU_REG_MODEM)
      modem_on <= wr_data_i[2:0];
  end

  // Receiver, sampling mid-bit with the configured format only
  cmu_ser_t    rx_st;
  logic [11:0] rx_cnt;
  logic [2:0]  rx_bit;
  logic [7:0]  rx_sh;
  logic        rx_parb;
  logic        rx_done;
  logic        rx_fe;
  logic        rx_pe;
  logic [7:0]  rx_byte;

  always_ff @(posedge mclk_i)
  begin
    rx_done <= 1'b0;
    if (sys_rst_i)
    begin
      rx_st   <= CMU_S_IDLE;
      rx_cnt  <= 12'h000;
      rx_bit  <= 3'h0;
      rx_sh   <= 8'h00;
      rx_parb <= 1'b0;
      rx_fe   <= 1'b0;
      rx_pe   <= 1'b0;
      rx_byte <= 8'h00;
    end
    else if (rx_st != CMU_S_IDLE && rx_cnt != 12'h000)
      rx_cnt <= rx_cnt - 12'h001;
    else
    begin
      rx_cnt <= bit_cyc - 12'h001;
      unique case (rx_st)
        CMU_S_IDLE:
        begin
          if (ab_done && !txd_i)
          begin
            rx_st  <= CMU_S_START;
            rx_cnt <= {1'b0, bit_cyc[11:1]};
          end
        end
        CMU_S_START:
        begin
          rx_bit <= 3'h0;
          rx_st  <= txd_i ? CMU_S_IDLE : CMU_S_DATA;
        end
        CMU_S_DATA:
        begin
          rx_sh  <= {txd_i, rx_sh[7:1]};
          rx_bit <= rx_bit + 3'h1;
          if (rx_bit == nbits_m1)
            rx_st <= (ctrl.parity == CMU_PAR_NONE) ? CMU_S_STOP : CMU_S_PAR;
        end
        CMU_S_PAR:
        begin
          rx_parb <= txd_i;
          rx_st   <= CMU_S_STOP;
        end
        CMU_S_STOP:
        begin
          rx_st   <= CMU_S_IDLE;
          rx_done <= 1'b1;
          rx_fe   <= !txd_i;
          rx_byte <= ctrl.data7 ? {1'b0, rx_sh[7:1]} : rx_sh;
          rx_pe   <= (ctrl.parity != CMU_PAR_NONE) &&
                     (rx_parb != cmu_par(ctrl.data7 ? {1'b0, rx_sh[7:1]}
                                         : rx_sh, ctrl.data7, ctrl.parity));
        end
      endcase
    end
  end

  logic is_flow_char;
  logic push_valid;
  logic push_ready;

  assign is_flow_char = (ctrl.flow == CMU_FLOW_SW) &&
                        (rx_byte == CMU_XON || rx_byte == CMU_XOFF);
  assign push_valid   = rx_done && !rx_fe && !is_flow_char;

  // Two-entry receive buffer drained by data register reads
  logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
  logic [PW-1:0]     buf_wp;
  logic [PW-1:0]     buf_rp;
  logic [PW:0]       buf_cnt;
  logic              pop_valid;
  logic              pop_ready;

  assign push_ready = (buf_cnt != FULL_CNT);
  assign pop_valid  = (buf_cnt != '0);
  assign pop_ready  = rd_rx;

  always_ff @(posedge mclk_i)
  begin
    if (push_valid && push_ready)
      buf_mem[buf_wp] <= rx_byte;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      buf_wp  <= '0;
      buf_rp  <= '0;
      buf_cnt <= '0;
    end
    else
    begin
      if (push_valid && push_ready)
        buf_wp <= buf_wp + 1'b1;
      if (pop_valid && pop_ready)
        buf_rp <= buf_rp + 1'b1;
      buf_cnt <= buf_cnt + (PW + 1)'(push_valid && push_ready)
                         - (PW + 1)'(pop_valid && pop_ready);
    end
  end

  // Sticky errors: a set in the clearing cycle wins
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      perr <= 1'b0;
      ferr <= 1'b0;
      ovr  <= 1'b0;
    end
    else
    begin
      perr <= (perr && !(wr_status && wr_data_i[CMU_ST_PERR]))
              || (rx_done && rx_pe);
      ferr <= (ferr && !(wr_status && wr_data_i[CMU_ST_FERR]))
              || (rx_done && rx_fe);
      ovr  <= (ovr && !(wr_status && wr_data_i[CMU_ST_OVR]))
              || (push_valid && !push_ready);
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i || ctrl.flow != CMU_FLOW_SW)
      xoff_rx <= 1'b0;
    else if (rx_done && !rx_fe && rx_byte == CMU_XOFF)
      xoff_rx <= 1'b1;
    else if (rx_done && !rx_fe && rx_byte == CMU_XON)
      xoff_rx <= 1'b0;
  end

  // Multiplex frame tracking: flag then address octet
  logic       mux_expect;
  logic       mux_seen;
  logic [5:0] mux_dlci;

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i || !ctrl.mux_en)
    begin
      mux_expect <= 1'b0;
      mux_seen   <= 1'b0;
      mux_dlci   <= 6'h00;
    end
    else if (push_valid)
    begin
      if (rx_byte == CMU_MUX_FLAG)
        mux_expect <= 1'b1;
      else if (mux_expect)
      begin
        mux_expect <= 1'b0;
        mux_seen   <= 1'b1;
        mux_dlci   <= rx_byte[7:2];
      end
    end
  end

  // Transmitter with in-band stop/go characters ahead of data
  cmu_ser_t    tx_st;
  logic [11:0] tx_cnt;
  logic [2:0]  tx_bit;
  logic [7:0]  tx_sh;
  logic        tx_parb;
  logic [7:0]  tx_hold;
  logic        tx_pend;
  logic        tx_allow;
  logic        need_xoff;
  logic        need_xon;
  logic        take_ctl;
  logic        take_data;
  logic [7:0]  load_byte;

  assign need_xoff = (ctrl.flow == CMU_FLOW_SW) && !sent_xoff &&
                     (buf_cnt >= STOP_CNT);
  assign need_xon  = (ctrl.flow == CMU_FLOW_SW) && sent_xoff &&
                     (buf_cnt == '0);
  assign tx_allow  = !sleep && ((ctrl.flow == CMU_FLOW_HW) ? !rts_i :
                     (ctrl.flow == CMU_FLOW_SW) ? !xoff_rx : 1'b1);
  assign take_ctl  = (tx_st == CMU_S_IDLE) && (need_xoff || need_xon);
  assign take_data = (tx_st == CMU_S_IDLE) && !take_ctl && tx_pend && tx_allow;
  assign load_byte = take_ctl ? (need_xoff ? CMU_XOFF : CMU_XON) : tx_hold;

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i || ctrl.flow != CMU_FLOW_SW)
      sent_xoff <= 1'b0;
    else if (take_ctl)
      sent_xoff <= need_xoff;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      tx_pend <= 1'b0;
      tx_hold <= 8'h00;
    end
    else if (take_data)
      tx_pend <= 1'b0;
    else if (wr_tx && !tx_pend)
    begin
      tx_pend <= 1'b1;
      tx_hold <= wr_data_i[7:0];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      tx_st   <= CMU_S_IDLE;
      tx_cnt  <= 12'h000;
      tx_bit  <= 3'h0;
      tx_sh   <= 8'h00;
      tx_parb <= 1'b0;
      rxd_o   <= 1'b1;
    end
    else if (tx_st != CMU_S_IDLE && tx_cnt != 12'h000)
      tx_cnt <= tx_cnt - 12'h001;
    else
    begin
      tx_cnt <= bit_cyc - 12'h001;
      unique case (tx_st)
        CMU_S_IDLE:
        begin
          if (take_ctl || take_data)
          begin
            tx_sh   <= load_byte;
            tx_parb <= cmu_par(load_byte, ctrl.data7, ctrl.parity);
            rxd_o   <= 1'b0;
            tx_st   <= CMU_S_START;
          end
        end
        CMU_S_START:
        begin
          rxd_o  <= tx_sh[0];
          tx_sh  <= {1'b0, tx_sh[7:1]};
          tx_bit <= 3'h0;
          tx_st  <= CMU_S_DATA;
        end
        CMU_S_DATA:
        begin
          if (tx_bit == nbits_m1)
          begin
            tx_bit <= 3'h0;
            if (ctrl.parity == CMU_PAR_NONE)
            begin
              rxd_o <= 1'b1;
              tx_st <= CMU_S_STOP;
            end
            else
            begin
              rxd_o <= tx_parb;
              tx_st <= CMU_S_PAR;
            end
          end
          else
          begin
            rxd_o  <= tx_sh[0];
            tx_sh  <= {1'b0, tx_sh[7:1]};
            tx_bit <= tx_bit + 3'h1;
          end
        end
        CMU_S_PAR:
        begin
          rxd_o <= 1'b1;
          tx_st <= CMU_S_STOP;
        end
        CMU_S_STOP:
        begin
          if (two_stop && tx_bit == 3'h0)
            tx_bit <= 3'h1;
          else
            tx_st <= CMU_S_IDLE;
        end
      endcase
    end
  end

  // Modem lines, ON drives the low level
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      cts_o <= 1'b1;
      dsr_o <= 1'b1;
      dcd_o <= 1'b1;
      ri_o  <= 1'b1;
    end
    else
    begin
      cts_o <= sleep || (buf_cnt >= STOP_CNT);
      dsr_o <= !modem_on[0];
      dcd_o <= !modem_on[1];
      ri_o  <= !modem_on[2];
    end
  end

  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (addr_i)
      CMU_REG_CTRL:   rd_word = 32'(ctrl);
      CMU_REG_STATUS: rd_word = {25'h0, ovr, ferr, perr, sleep, ab_done,
                                 tx_pend || tx_st != CMU_S_IDLE, pop_valid};
      CMU_REG_RXDATA: rd_word = {24'h0, pop_valid ? buf_mem[buf_rp] : 8'h00};
      CMU_REG_MODEM:  rd_word = {27'h0, !dtr_i, !rts_i, modem_on};
      CMU_REG_MUX:    rd_word = {22'h0, mux_seen, mux_dlci == 6'h00,
                                 mux_dlci <= CMU_MUX_LAST, xoff_rx,
                                 mux_dlci};
      default:        rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      rd_data_o <= 32'h0000_0000;
    else
      rd_data_o <= rd_en_i ? rd_word : 32'h0000_0000;
  end

endmodule

/* verification/cmu_uart_port_chk.sv */
// Port-level assertions of the modem serial port
module cmu_uart_port_chk
  import cmu_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic [31:0] rd_data_o,
  input wire logic        txd_i,
  input wire logic        rts_i,
  input wire logic        dtr_i,
  input wire logic        rxd_o,
  input wire logic        cts_o,
  input wire logic        dsr_o,
  input wire logic        dcd_o,
  input wire logic        ri_o
);
  logic [1:0]  flow;
  logic [15:0] rts_cnt;
  logic [2:0]  mdm;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // Shadow of the flow field, last software value wins
  always_ff @(posedge mclk_i)
    if (sys_rst_i)
      flow <= CMU_FLOW_HW;
    else if (wr_en_i && addr_i == CMU_REG_CTRL)
      flow <= wr_data_i[8:7];

  // Cycles that RTS has been OFF, longer than any frame
  always_ff @(posedge mclk_i)
    if (sys_rst_i || !rts_i)
      rts_cnt <= 16'h0;
    else if (rts_cnt != 16'hffff)
      rts_cnt <= rts_cnt + 16'h1;

  always_ff @(posedge mclk_i)
    if (wr_en_i && addr_i == CMU_REG_MODEM)
      mdm <= wr_data_i[2:0];

  rst_idle_a: assert property (disable iff (1'b0)
    sys_rst_i |=> rxd_o && cts_o && dsr_o && dcd_o && ri_o
    && rd_data_o == 32'h0) else $error("outputs not idle in reset");
  cts_on_a: assert property ($fell(sys_rst_i) |=> !cts_o)
    else $error("cts not on after reset");
  rd_zero_a: assert property (!rd_en_i |=> rd_data_o == 32'h0)
    else $error("read data outside read cycle");
  unmapped_a: assert property (rd_en_i && addr_i > CMU_REG_MUX
    |=> rd_data_o == 32'h0) else $error("unmapped read not zero");
  start_bit_a: assert property ($fell(rxd_o) |=> !rxd_o [*8])
    else $error("start bit too short");
  cts_busy_a: assert property (rd_en_i && addr_i == CMU_REG_STATUS
    ##1 (rd_data_o[0] || rd_data_o[3]) |-> ##[0:1] cts_o)
    else $error("cts on while full or asleep");
  modem_out_a: assert property (wr_en_i && addr_i == CMU_REG_MODEM
    |=> ##1 {ri_o, dcd_o, dsr_o} == ~mdm)
    else $error("modem lines do not follow register");
  hw_hold_a: assert property (flow == CMU_FLOW_HW
    && rts_cnt > 16'h7d00 |-> !$fell(rxd_o))
    else $error("frame sent while rts off");

  cover property (rd_en_i && addr_i == CMU_REG_RXDATA);
  cover property ($rose(cts_o));
  cover property (rts_cnt > 16'h7d00);
endmodule

bind cmu_uart_port cmu_uart_port_chk u_chk (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
  .rd_data_o(rd_data_o), .txd_i(txd_i), .rts_i(rts_i), .dtr_i(dtr_i),
  .rxd_o(rxd_o), .cts_o(cts_o), .dsr_o(dsr_o), .dcd_o(dcd_o),
  .ri_o(ri_o));

/* verification/cmu_host_model.sv */
// Host terminal model: sends and receives framed characters
module cmu_host_model (
  input  wire logic clk_i,
  input  wire logic rxd_i,
  input  wire logic cts_i,
  output logic      txd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int         cyc = 217;
  int         nb  = 8;
  logic [1:0] par = 2'h0;
  logic       st2 = 1'b0;
  logic       hw  = 1'b1;
  logic [7:0] rq [$];

  initial txd_o = 1'b1;

  task automatic bitout(logic b, int n);
    txd_o <= b;
    repeat (n) @(posedge clk_i);
  endtask

  // Bad flips parity, or without parity pulls the stop bit low
  task automatic send(logic [7:0] d, logic bad);
    logic p;
    @(posedge clk_i);
    while (hw && cts_i) @(posedge clk_i);
    p = (nb == 7 ? ^d[6:0] : ^d) ^ (par == 2'h2) ^ bad;
    bitout(1'b0, cyc);
    for (int i = 0; i < nb; i++) bitout(d[i], cyc);
    if (par != 2'h0) bitout(p, cyc);
    bitout(!(bad && par == 2'h0), (st2 && par == 2'h0) ? 2 * cyc : cyc);
    if (bad && par == 2'h0) bitout(1'b1, cyc);
  endtask

  always
  begin
    logic [7:0] d;
    @(negedge rxd_i);
    d = 8'h0;
    repeat (cyc / 2) @(posedge clk_i);
    for (int i = 0; i < nb; i++)
    begin
      repeat (cyc) @(posedge clk_i);
      d[i] = rxd_i;
    end
    repeat ((par != 2'h0) ? 2 * cyc : cyc) @(posedge clk_i);
    rq.push_back(d);
  end
endmodule

/* verification/tb_cmu_uart_port.sv */
// Self-checking bench of the modem serial port
module tb_cmu_uart_port
  import cmu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i, sys_rst_i, wr_en_i, rd_en_i, txd_i, rts_i, dtr_i;
  logic        rxd_o, cts_o, dsr_o, dcd_o, ri_o;
  logic [7:0]  addr_i, m;
  logic [31:0] wr_data_i, rd_data_o, v;
  int          fail_count, tests_run;

  cmu_uart_port i_cmu_uart_port (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .txd_i(txd_i),
    .rts_i(rts_i), .dtr_i(dtr_i), .rxd_o(rxd_o), .cts_o(cts_o),
    .dsr_o(dsr_o), .dcd_o(dcd_o), .ri_o(ri_o));
  cmu_host_model u_host (.clk_i(mclk_i), .rxd_i(rxd_o), .cts_i(cts_o),
    .txd_o(txd_i));

  initial
  begin
    {mclk_i, wr_en_i, rd_en_i, rts_i, dtr_i, addr_i, wr_data_i} = '0;
    sys_rst_i = 1'b1;
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge mclk_i);
    wr_en_i   <= 1'b1;
    addr_i    <= a;
    wr_data_i <= d;
    @(posedge mclk_i);
    wr_en_i <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a);
    @(posedge mclk_i);
    rd_en_i <= 1'b1;
    addr_i  <= a;
    @(posedge mclk_i);
    rd_en_i <= 1'b0;
    #1 v = rd_data_o;
  endtask

  task automatic rdc(string n, logic [7:0] a, logic [31:0] e,
                     logic [31:0] k);
    rd(a);
    chk(n, e & k, v & k);
  endtask

  task automatic host_got(string n, logic [7:0] e);
    for (int k = 0; k < 40000 && u_host.rq.size() == 0; k++) idle(1);
    if (u_host.rq.size() == 0)
      chk(n, {24'h0, e}, 32'hx);
    else
      chk(n, {24'h0, e}, {24'h0, u_host.rq.pop_front()});
  endtask

  task automatic do_reset;
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    idle(4);
    sys_rst_i <= 1'b0;
  endtask

  task automatic t_reset;
    rdc("ctrl", CMU_REG_CTRL, 32'h1004, 32'h3fff);
    rdc("det", CMU_REG_STATUS, 32'h0, 32'h4);
    rdc("unmapped", 8'h20, 32'h0, 32'hffffffff);
    chk("cts", 32'h0, {31'h0, cts_o});
  endtask

  task automatic t_noab;
    do_reset();
    wr(CMU_REG_CTRL, 32'h0004);
    u_host.send(8'h3c, 1'b0);
    idle(300);
    rdc("rx_dflt", CMU_REG_RXDATA, 32'h3c, 32'hff);
  endtask

  task automatic t_abd;
    do_reset();
    u_host.cyc = 434;
    u_host.send(8'h41, 1'b0);
    idle(434 * 12);
    rdc("rate", CMU_REG_CTRL, 32'h3, 32'h7);
    rdc("done", CMU_REG_STATUS, 32'h4, 32'h5);
    u_host.send(8'h5a, 1'b0);
    idle(500);
    rdc("rx_det", CMU_REG_RXDATA, 32'h5a, 32'hff);
  endtask

  // Format code is {seven bits, parity, two stops}
  task automatic t_fmt;
    logic [3:0] f [8] = '{4'h1, 4'h0, 4'h2, 4'h4, 4'h9, 4'h8, 4'ha, 4'hc};
    u_host.cyc = 27;
    u_host.hw  = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      u_host.nb  = f[i][3] ? 7 : 8;
      u_host.par = f[i][2:1];
      u_host.st2 = f[i][0];
      m = f[i][3] ? 8'h7f : 8'hff;
      wr(CMU_REG_CTRL, 32'h1107 | {f[i][0], f[i][2:1], f[i][3], 3'h0});
      u_host.send(8'hd3, 1'b0);
      idle(40);
      rdc("fmt_rx", CMU_REG_RXDATA, {24'h0, 8'hd3 & m}, 32'hff);
      wr(CMU_REG_TXDATA, 32'hb6);
      host_got("fmt_tx", 8'hb6 & m);
      idle(60);
      if (f[i][2:1] != 2'h0)
      begin
        u_host.send(8'h5c, 1'b1);
        idle(40);
        rdc("par_err", CMU_REG_STATUS, 32'h11, 32'h11);
        wr(CMU_REG_STATUS, 32'h10);
        rd(CMU_REG_RXDATA);
      end
    end
    {u_host.nb, u_host.par, u_host.st2} = {32'd8, 3'h0};
  endtask

  task automatic t_buf;
    wr(CMU_REG_CTRL, 32'h1107);
    for (int i = 0; i < 3; i++) u_host.send(8'h61 + 8'(i), 1'b0);
    idle(40);
    chk("cts_full", 32'h1, {31'h0, cts_o});
    rdc("ovr", CMU_REG_STATUS, 32'h41, 32'h41);
    rdc("buf0", CMU_REG_RXDATA, 32'h61, 32'hff);
    rdc("buf1", CMU_REG_RXDATA, 32'h62, 32'hff);
    rdc("empty", CMU_REG_RXDATA, 32'h0, 32'hffffffff);
    idle(2);
    chk("cts_free", 32'h0, {31'h0, cts_o});
    wr(CMU_REG_STATUS, 32'h40);
    u_host.send(8'h55, 1'b1);
    idle(40);
    rdc("frm_err", CMU_REG_STATUS, 32'h20, 32'h21);
    wr(CMU_REG_STATUS, 32'h20);
  endtask

  task automatic t_hw;
    wr(CMU_REG_CTRL, 32'h1007);
    u_host.hw = 1'b1;
    u_host.send(8'h71, 1'b0);
    fork
      u_host.send(8'h72, 1'b0);
    join_none
    idle(600);
    rdc("no_ovr", CMU_REG_STATUS, 32'h0, 32'h40);
    for (int k = 0; k < 2; k++)
    begin
      rdc("hw_rx", CMU_REG_RXDATA, 32'h71 + k, 32'hff);
      idle(400);
    end
    rts_i <= 1'b1;
    wr(CMU_REG_TXDATA, 32'h44);
    idle(33000);
    chk("hw_hold", 32'h0, u_host.rq.size());
    rts_i <= 1'b0;
    host_got("hw_go", 8'h44);
  endtask

  task automatic t_sw;
    wr(CMU_REG_CTRL, 32'h1087);
    u_host.hw = 1'b0;
    u_host.send(8'h65, 1'b0);
    host_got("xoff", CMU_XOFF);
    rdc("sw_rx", CMU_REG_RXDATA, 32'h65, 32'hff);
    host_got("xon", CMU_XON);
    u_host.send(CMU_XOFF, 1'b0);
    wr(CMU_REG_TXDATA, 32'h46);
    idle(600);
    chk("sw_hold", 32'h0, u_host.rq.size());
    u_host.send(CMU_XON, 1'b0);
    host_got("sw_go", 8'h46);
  endtask

  task automatic t_psv;
    wr(CMU_REG_CTRL, 32'h1b07);
    idle(4);
    chk("sleep_cts", 32'h1, {31'h0, cts_o});
    rdc("sleep_st", CMU_REG_STATUS, 32'h8, 32'h8);
    for (int i = 0; i < 2; i++)
    begin
      wr(CMU_REG_CTRL, i ? 32'h1707 : 32'h1507);
      rts_i <= (i == 0);
      dtr_i <= (i == 1);
      idle(4);
      chk("line_off", 32'h1, {31'h0, cts_o});
      rts_i <= 1'b0;
      dtr_i <= 1'b0;
      idle(4);
      chk("line_on", 32'h0, {31'h0, cts_o});
    end
  endtask

  task automatic t_misc;
    wr(CMU_REG_MODEM, 32'h5);
    idle(3);
    chk("modem", 32'h2, {29'h0, ri_o, dcd_o, dsr_o});
    rdc("modem_rd", CMU_REG_MODEM, 32'h1d, 32'h1f);
    wr(CMU_REG_CTRL, 32'h3107);
    for (int k = 0; k < 2; k++)
    begin
      u_host.send(CMU_MUX_FLAG, 1'b0);
      u_host.send(k ? 8'h03 : 8'h09, 1'b0);
      idle(40);
      rdc("mux", CMU_REG_MUX, k ? 32'h380 : 32'h282, 32'h3ff);
      rd(CMU_REG_RXDATA);
      rd(CMU_REG_RXDATA);
    end
  endtask

  initial
  begin
    do_reset();
    t_reset();
    t_noab();
    t_abd();
    t_fmt();
    t_buf();
    t_hw();
    t_sw();
    t_psv();
    t_misc();
    end_sim();
  end

  // Run needs about 60000 cycles; cut off at 100000
  initial
  begin
    #4_000_000;
    fail_count++;
    end_sim();
  end
endmodule
